// ---- rtl/oalp_regs.vh ----
// register offsets, opcode encodings and reset values of the or/pointer-load execution block
`ifndef OALP_REGS_VH
`define OALP_REGS_VH

// register port offsets, 8-bit data
`define OALP_REG_ACC      4'h0
`define OALP_REG_STATUS   4'h1
`define OALP_REG_BANK     4'h2
`define OALP_REG_CONFIG   4'h3
`define OALP_REG_PTR0_HI  4'h4
`define OALP_REG_PTR0_LO  4'h5
`define OALP_REG_PTR1_HI  4'h6
`define OALP_REG_PTR1_LO  4'h7
`define OALP_REG_PTR2_HI  4'h8
`define OALP_REG_PTR2_LO  4'h9
`define OALP_REG_MEMA_LO  4'ha
`define OALP_REG_MEMA_HI  4'hb
`define OALP_REG_MEMDATA  4'hc

// field positions and the bank field width
`define OALP_STATUS_ZERO  0
`define OALP_STATUS_NEG   1
`define OALP_CONFIG_EXT   0
`define OALP_BANK_W       4

// opcode encodings: the fixed upper bits of each opcode, and bit positions of its destination and access flags
`define OALP_OPC_ORLIT    8'h09
`define OALP_OPC_ORREG    6'h04
`define OALP_OPC_LDPTR    10'h3b8
`define OALP_DEST_BIT     9
`define OALP_ACCESS_BIT   8

// addressing constants
`define OALP_INDEX_MAX    8'h5f
`define OALP_ACCESS_SPLIT 8'h60
`define OALP_ACCESS_HIGH  4'hf
`define OALP_INDEX_PTR    2'h2

// reset values
`define OALP_RST_ACC      8'h00
`define OALP_RST_BANK     4'h0
`define OALP_RST_PTR      8'h00
`define OALP_RST_CONFIG   1'b0

`endif

// ---- rtl/oalp_dmem.v ----
// data memory with synchronous write and registered read
`timescale 1ns/1ps
`default_nettype none
module oalp_dmem #(
  parameter AW = 12,
  parameter DW = 8
) (
  input wire clk,
  input wire [AW-1:0] addr,
  input wire we,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ---- rtl/oalp_exec.v ----
// execution core for literal-or, register-or and two-word pointer load
// What this block does
// - literal-or ors the accumulator with the 8-bit immediate, writes the accumulator, sets N and Z.
// - register-or ors the accumulator with the addressed data register and sets N and Z.
// - register-or destination bit 0 writes the accumulator, 1 writes the addressed register.
// - access bit 0 resolves the 8-bit address inside the access bank.
// - access bit 1 forms the address from the bank select register and the 8-bit field.
// - access bit 0, extended set on and field up to 5fh uses indexed literal offset addressing.
// - pointer load puts a 12-bit immediate into the selected one of three pointers, no flags.
// - the 8-bit address field reaches every location of a 256-byte bank.
`timescale 1ns/1ps
`default_nettype none
`include "oalp_regs.vh"
module oalp_exec #(
  parameter AW = 12,
  parameter ACCESS_SPLIT = `OALP_ACCESS_SPLIT
) (
  input wire clk,
  input wire reset,
  input wire [15:0] instr_word,
  input wire instr_valid,
  output reg instr_ready,
  output reg exec_done,
  output reg [7:0] acc,
  output reg flag_neg,
  output reg flag_zero,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata
);
  localparam S_IDLE = 6'b000001;
  localparam S_Q1 = 6'b000010;
  localparam S_Q2 = 6'b000100;
  localparam S_Q3 = 6'b001000;
  localparam S_Q4 = 6'b010000;
  localparam S_WAIT = 6'b100000;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [15:0] ir;
  reg second_word;
  reg [1:0] ptr_sel;
  reg [3:0] ptr_upper;
  reg is_orlit;
  reg is_orreg;
  reg is_ldptr;
  reg [AW-1:0] exec_addr;
  reg [7:0] result;
  reg [`OALP_BANK_W-1:0] bank_select_reg;
  reg ext_enable;
  reg [7:0] pointer_high_byte [0:2];
  reg [7:0] pointer_low_byte [0:2];
  reg [AW-1:0] mem_addr;
  wire [7:0] mem_q;
  reg [AW-1:0] dm_addr;
  reg dm_we;
  reg [7:0] dm_wdata;
  wire busy;
  wire [AW-1:0] index_base;

  assign busy = (state != S_IDLE);
  assign index_base = {pointer_high_byte[`OALP_INDEX_PTR][AW-9:0],
                       pointer_low_byte[`OALP_INDEX_PTR]};

  // effective data address of a byte-oriented operand
  function [AW-1:0] eff_addr;
    input [7:0] f;
    input a;
    input ext;
    input [`OALP_BANK_W-1:0] bank;
    input [AW-1:0] base;
    begin
      if (!a && ext && (f <= `OALP_INDEX_MAX))
      begin
        eff_addr = base + {{(AW-8){1'b0}}, f};
      end
      else if (!a)
      begin
        if (f < ACCESS_SPLIT)
        begin
          eff_addr = {{(AW-8){1'b0}}, f};
        end
        else
        begin
          eff_addr = {`OALP_ACCESS_HIGH, f};
        end
      end
      else
      begin
        eff_addr = {bank, f};
      end
    end
  endfunction

  oalp_dmem #(
    .AW(AW),
    .DW(8)
  ) u_dmem (
    .clk(clk),
    .addr(dm_addr),
    .we(dm_we),
    .wdata(dm_wdata),
    .rdata(mem_q)
  );

  // core owns the memory in Q1 to Q4; software writes reach it when idle or waiting for the second word, reads only when idle
  always @*
  begin
    dm_addr = mem_addr;
    dm_we = 1'b0;
    dm_wdata = reg_wdata;
    if (busy && state != S_WAIT)
    begin
      dm_addr = exec_addr;
      dm_wdata = result;
      dm_we = (state == S_Q4) && is_orreg && ir[`OALP_DEST_BIT];
    end
    else if (reg_write && reg_addr == `OALP_REG_MEMDATA)
    begin
      dm_we = 1'b1;
    end
  end

  always @*
  begin
    case (state)
      // ready is low for one cycle after reset, so valid alone must not start a cycle
      S_IDLE: next_state = (instr_valid && instr_ready) ? S_Q1 : S_IDLE;
      S_Q1: next_state = S_Q2;
      S_Q2: next_state = S_Q3;
      S_Q3: next_state = S_Q4;
      S_Q4: next_state = (is_ldptr && !second_word) ? S_WAIT : S_IDLE;
      S_WAIT: next_state = (instr_valid && instr_ready) ? S_Q1 : S_WAIT;
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      instr_ready <= 1'b0;
      exec_done <= 1'b0;
      ir <= 16'h0000;
      second_word <= 1'b0;
      ptr_sel <= 2'h0;
      ptr_upper <= 4'h0;
      is_orlit <= 1'b0;
      is_orreg <= 1'b0;
      is_ldptr <= 1'b0;
      exec_addr <= {AW{1'b0}};
      result <= 8'h00;
    end
    else
    begin
      state <= next_state;
      instr_ready <= (next_state == S_IDLE) || (next_state == S_WAIT);
      exec_done <= (state == S_Q4) && (next_state == S_IDLE);
      if (instr_valid && instr_ready)
      begin
        ir <= instr_word;
      end
      if (state == S_Q1)
      begin
        // decode phase; second word of a pointer load keeps first decode
        if (!second_word)
        begin
          is_orlit <= (ir[15:8] == `OALP_OPC_ORLIT);
          is_orreg <= (ir[15:10] == `OALP_OPC_ORREG);
          is_ldptr <= (ir[15:6] == `OALP_OPC_LDPTR);
          ptr_sel <= ir[5:4];
          ptr_upper <= ir[3:0];
        end
        exec_addr <= eff_addr(ir[7:0], ir[`OALP_ACCESS_BIT], ext_enable,
                              bank_select_reg, index_base);
      end
      if (state == S_Q3)
      begin
        // mem_q holds the operand read during Q2
        if (is_orlit)
        begin
          result <= acc | ir[7:0];
        end
        else
        begin
          result <= acc | mem_q;
        end
      end
      if (state == S_Q4)
      begin
        second_word <= is_ldptr && !second_word;
      end
    end
  end

  // architectural state and software port
  always @(posedge clk)
  begin
    if (reset)
    begin
      acc <= `OALP_RST_ACC;
      flag_neg <= 1'b0;
      flag_zero <= 1'b0;
      bank_select_reg <= `OALP_RST_BANK;
      ext_enable <= `OALP_RST_CONFIG;
      mem_addr <= {AW{1'b0}};
      reg_rdata <= 8'h00;
      pointer_high_byte[0] <= `OALP_RST_PTR;
      pointer_high_byte[1] <= `OALP_RST_PTR;
      pointer_high_byte[2] <= `OALP_RST_PTR;
      pointer_low_byte[0] <= `OALP_RST_PTR;
      pointer_low_byte[1] <= `OALP_RST_PTR;
      pointer_low_byte[2] <= `OALP_RST_PTR;
    end
    else
    begin
      if (reg_write)
      begin
        case (reg_addr)
          `OALP_REG_ACC: acc <= reg_wdata;
          `OALP_REG_BANK: bank_select_reg <= reg_wdata[`OALP_BANK_W-1:0];
          `OALP_REG_CONFIG: ext_enable <= reg_wdata[`OALP_CONFIG_EXT];
          `OALP_REG_MEMA_LO: mem_addr[7:0] <= reg_wdata;
          `OALP_REG_MEMA_HI: mem_addr[AW-1:8] <= reg_wdata[AW-9:0];
          default: ;
        endcase
      end
      // core write phase wins over a software write in the same cycle
      if (state == S_Q4 && (is_orlit || is_orreg))
      begin
        if (is_orlit || !ir[`OALP_DEST_BIT])
        begin
          acc <= result;
        end
        flag_neg <= result[7];
        flag_zero <= (result == 8'h00);
      end
      // pointer load: no flag touched; selector 3 names no pointer and is dropped
      if (state == S_Q4 && is_ldptr && ptr_sel != 2'h3)
      begin
        if (!second_word)
        begin
          pointer_high_byte[ptr_sel] <= {4'h0, ptr_upper};
        end
        else
        begin
          pointer_low_byte[ptr_sel] <= ir[7:0];
        end
      end
      reg_rdata <= 8'h00;
      if (reg_read)
      begin
        case (reg_addr)
          `OALP_REG_ACC: reg_rdata <= acc;
          `OALP_REG_STATUS: reg_rdata <= {6'h00, flag_neg, flag_zero};
          `OALP_REG_BANK: reg_rdata <= {{(8-`OALP_BANK_W){1'b0}}, bank_select_reg};
          `OALP_REG_CONFIG: reg_rdata <= {7'h00, ext_enable};
          `OALP_REG_PTR0_HI: reg_rdata <= pointer_high_byte[0];
          `OALP_REG_PTR0_LO: reg_rdata <= pointer_low_byte[0];
          `OALP_REG_PTR1_HI: reg_rdata <= pointer_high_byte[1];
          `OALP_REG_PTR1_LO: reg_rdata <= pointer_low_byte[1];
          `OALP_REG_PTR2_HI: reg_rdata <= pointer_high_byte[2];
          `OALP_REG_PTR2_LO: reg_rdata <= pointer_low_byte[2];
          `OALP_REG_MEMA_LO: reg_rdata <= mem_addr[7:0];
          `OALP_REG_MEMA_HI: reg_rdata <= {{(16-AW){1'b0}}, mem_addr[AW-1:8]};
          // prefetched word at mem_addr; stale for one cycle after a change
          `OALP_REG_MEMDATA: reg_rdata <= busy ? 8'h00 : mem_q;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/oalp_exec_chk.sv ----
// assertions on the ports of the or/pointer-load execution core
`timescale 1ns/1ps
`default_nettype none
module oalp_exec_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic exec_done,
  input wire logic [7:0] acc,
  input wire logic flag_neg,
  input wire logic flag_zero
);
  // ----------------------------
  // instruction timing and results
  // ----------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence take;
    instr_valid && instr_ready;
  endsequence
  sequence take_lit;
    take ##0 instr_word[15:8] == 8'h09;
  endsequence
  sequence take_reg;
    take ##0 instr_word[15:10] == 6'h04;
  endsequence
  sequence take_ptr;
    take ##0 instr_word[15:6] == 10'h3b8;
  endsequence
  chk_lit_done: assert property (take_lit |-> ##5 exec_done)
    else $error("literal or late");
  chk_busy_refuse: assert property (take |=> !instr_ready [*4])
    else $error("ready during execution");
  chk_lit_result: assert property (take_lit |-> ##5 acc == ($past(acc, 5) | $past(instr_word[7:0], 5)))
    else $error("literal or result wrong");
  chk_flag_copy: assert property (take_lit |-> ##5 flag_neg == acc[7] && flag_zero == (acc == 8'h00))
    else $error("flags do not follow result");
  chk_reg_done: assert property (take_reg |-> ##5 exec_done)
    else $error("register or late");
  chk_dest_keep: assert property (take_reg ##0 instr_word[9] |-> ##5 acc == $past(acc, 5))
    else $error("accumulator changed");
  chk_ptr_flags: assert property (take_ptr |-> ##1 ($stable(flag_neg) && $stable(flag_zero)) [*5])
    else $error("pointer load touched flags");
  chk_ptr_wait: assert property (take_ptr |-> ##5 instr_ready && !exec_done)
    else $error("pointer load did not wait");
endmodule
bind oalp_exec oalp_exec_chk u_chk (.clk(clk), .reset(reset), .instr_word(instr_word),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .exec_done(exec_done), .acc(acc),
  .flag_neg(flag_neg), .flag_zero(flag_zero));
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the or/pointer-load execution core
`timescale 1ns/1ps
`default_nettype none
`include "oalp_regs.vh"
module tb_top;
  logic clk = 0;
  logic reset = 1;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 0;
  logic reg_read = 0;
  wire instr_ready, exec_done, flag_neg, flag_zero;
  wire [7:0] acc, reg_rdata;
  logic [7:0] rd;
  logic [11:0] k;
  logic [3:0] i;
  integer fails = 0;
  integer compares = 0;
  logic [31:0] rows [0:3] = '{32'h9a35bf02, 32'h00000001, 32'h01404100, 32'h00808002};
  oalp_exec uut (.clk(clk), .reset(reset), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .exec_done(exec_done), .acc(acc), .flag_neg(flag_neg),
    .flag_zero(flag_zero), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  initial forever #50 clk = ~clk;
  // ----------------------------
  // bus and check tasks
  // ----------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 0;
    end
  endtask
  task rdr(input [3:0] a);
    begin
      @(posedge clk);
      reg_read <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 0;
      #1 rd = reg_rdata;
    end
  endtask
  task mem(input [11:0] a, input [7:0] d);
    begin
      wr(`OALP_REG_MEMA_LO, a[7:0]);
      wr(`OALP_REG_MEMA_HI, {4'h0, a[11:8]});
      wr(`OALP_REG_MEMDATA, d);
    end
  endtask
  // holds the word until an edge sees ready, then waits four cycles: done stands in the fifth
  task ins(input [15:0] w);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      instr_valid <= 1;
      instr_word <= w;
      @(posedge clk);
      while (instr_ready !== 1'b1 && n < 20)
      begin
        n = n + 1;
        @(posedge clk);
      end
      instr_valid <= 0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task run(input [7:0] a0, input [15:0] w, input [7:0] ea, input [1:0] nz);
    begin
      wr(`OALP_REG_ACC, a0);
      ins(w);
      chk({7'h0, exec_done}, 8'h01);
      chk(acc, ea);
      chk({6'h0, flag_neg, flag_zero}, {6'h0, nz});
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #2000000;
    fails = fails + 1;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 0;
    rdr(`OALP_REG_PTR0_HI);
    chk(rd, 8'h00);
    rdr(4'hf);
    chk(rd, 8'h00);
    for (int r = 0; r < 4; r++)
      run(rows[r][31:24], {8'h09, rows[r][23:16]}, rows[r][15:8], rows[r][1:0]);
    for (i = 0; i < 3; i++)
    begin
      k = 12'h3ab + 12'h111 * (12'h2 - {8'h0, i});
      ins({8'hee, 2'b00, i[1:0], k[11:8]});
      chk({6'h0, instr_ready, exec_done}, 8'h02);
      ins({8'h00, k[7:0]});
      chk({6'h0, flag_neg, exec_done}, 8'h03);
      rdr(4'h4 + {i[2:0], 1'b0});
      chk(rd, {4'h0, k[11:8]});
      rdr(4'h5 + {i[2:0], 1'b0});
      chk(rd, k[7:0]);
    end
    wr(`OALP_REG_BANK, 8'h03);
    mem(12'h345, 8'h10);
    run(8'h01, 16'h1145, 8'h11, 2'b00);
    mem(12'h3ff, 8'h80);
    run(8'h02, 16'h13ff, 8'h02, 2'b10);
    rdr(`OALP_REG_MEMDATA);
    chk(rd, 8'h82);
    mem(12'h020, 8'h04);
    run(8'h00, 16'h1020, 8'h04, 2'b00);
    mem(12'hf80, 8'h40);
    run(8'h01, 16'h1080, 8'h41, 2'b00);
    wr(`OALP_REG_CONFIG, 8'h01);
    mem(12'h40a, 8'h20);
    run(8'h01, 16'h105f, 8'h21, 2'b00);
    mem(12'hf60, 8'h02);
    run(8'h00, 16'h1060, 8'h02, 2'b00);
    // ----------------------------
    // mid-run reset, word offered before ready
    // ----------------------------
    @(posedge clk);
    reset <= 1;
    repeat (4) @(posedge clk);
    reset <= 0;
    instr_valid <= 1;
    instr_word <= 16'h0955;
    #1 chk({4'h0, instr_ready, exec_done, flag_neg, flag_zero}, 8'h00);
    chk(acc, 8'h00);
    @(posedge clk);
    @(posedge clk);
    instr_valid <= 0;
    repeat (4) @(posedge clk);
    #1 chk({7'h0, exec_done}, 8'h01);
    chk(acc, 8'h55);
    chk({6'h0, flag_neg, flag_zero}, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
